// ### hw/timer_pwm_interrupt_control.sv
// Purpose: 16-bit timer with PWM mode, captures, flags and interrupt request
// Assumes: APB slave, one clock pclk at 25 MHz, pins synchronised here
// Notes:   Answers every transfer after one wait cycle
//
// What this block does
// RQ1: PWM mode makes a cyclic output from duty and period compare values.
// RQ2: PWM mode takes over compare one and period compare entirely.
// RQ3: Compare values double-buffered in PWM, applied only at period match.
// RQ4: Duty match drives duty level; period match drives period level on pin.
// RQ5: Software loads compares, levels, pin enable, PWM bit and clock select.
// RQ6: Duty level 1, period level 0 gives high pulse of period minus duty.
// RQ7: Equal levels keep the pin steady at that level.
// RQ8: Counter ticks at CPU clock over 2, 4, 8, or external edges.
// RQ9: PWM period match reloads the counter with FFFC.
// RQ10: High byte write suspends that compare until low byte written.
// RQ11: Compare flags never set by hardware in PWM mode.
// RQ12: PWM period match sets capture flag one; interrupt if enabled, unmasked.
// RQ13: PWM disconnects capture one; capture two still works.
// RQ14: PWM bit wins over single-pulse bit.
// RQ15: Wait state leaves timer running; its interrupt wakes the device.
// RQ16: Halt freezes counter and prescaler, registers stay accessible; resumes from held value.
// RQ17: Capture edge in halt arms; wake sets flag and captures counter.
// RQ18: One interrupt output, each event gated by its enable and global mask.
// RQ19: Three control/status registers plus six 16-bit data register pairs.
// RQ20: Control register a is 8-bit RW, reset 00, fixed bit order.
// RQ21: Capture enable raises interrupt on either capture flag.
// RQ22: Compare enable raises interrupt on either compare flag.
// RQ23: Clock select 00 div4, 01 div2, 10 div8, 11 external.
// RQ24: Overflow enable raises interrupt on overflow flag.
// RQ25: Period level is driven on the output pin at period match.
// RQ26: Capture flag one cleared by status read then capture one low access.
// RQ27: Counter advances one per tick; compares checked every tick.
`include "timer_pwm_params.svh"
`timescale 1ns/1ps

module timer_pwm_interrupt_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        capture_input_one,
  input  wire logic        capture_input_two,
  input  wire logic        ext_clk_pin,
  input  wire logic        halt_mode,
  output logic             pwm_out_pin,
  output logic             compare_out_two,
  output logic             timer_irq
);

  // ========================================================================
  // Pin synchronisers
  logic [2:0] meta_ff, sync_ff, sync_d_ff, nxt_meta;
  always_comb begin
    nxt_meta = {ext_clk_pin, capture_input_two, capture_input_one};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff   <= 3'h0;
      sync_ff   <= 3'h0;
      sync_d_ff <= 3'h0;
    end else begin
      meta_ff   <= nxt_meta;
      sync_ff   <= meta_ff;
      sync_d_ff <= sync_ff;
    end
  end

  // ========================================================================
  // Register state
  logic [7:0]  ctrl_a_ff, ctrl_b_ff, nxt_ctrl_a, nxt_ctrl_b;
  logic        timer_off_ff, irq_mask_ff, nxt_timer_off, nxt_irq_mask;
  logic [15:0] cmp1_ff, cmp2_ff, nxt_cmp1, nxt_cmp2;
  logic [1:0]  inhibit_ff, nxt_inhibit;
  logic [15:0] cnt_ff, duty_act_ff, period_act_ff, nxt_cnt, nxt_duty_act, nxt_period_act;
  logic [2:0]  pre_ff, nxt_pre;
  logic        lat1_ff, lat2_ff, nxt_lat1, nxt_lat2;
  logic        pwm_out_ff, out_two_ff, nxt_pwm_out, nxt_out_two;
  logic [4:0]  flags_ff, clr_arm_ff, nxt_flags, nxt_clr_arm;
  logic [15:0] cap1_ff, cap2_ff, nxt_cap1, nxt_cap2;
  logic [1:0]  arm_ff, nxt_arm;
  logic        irq_ff, nxt_irq;
  timer_pwm_pkg::power_state_e state_ff, nxt_state;
  logic        pready_ff, pslverr_ff, nxt_pready, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;

  // ========================================================================
  // Decoded controls
  logic       pwm_on, one_shot_on, halted, exit_halt, run, tick;
  logic       cap1_edge, cap2_edge, ext_edge, m1, m2, reload, ovf_ev;
  logic [1:0] clk_sel;
  logic [2:0] rise, fall;
  logic       done, wr_done, rd_done;

  assign pwm_on      = ctrl_b_ff[`BIT_PWM];                                  // [RQ2]
  assign one_shot_on = ctrl_b_ff[`BIT_ONE_SHOT] & ~pwm_on;                   // [RQ14]
  assign clk_sel     = ctrl_b_ff[`BIT_CLK_HI:`BIT_CLK_LO];
  assign halted      = (state_ff == timer_pwm_pkg::ST_HALT);
  assign exit_halt   = halted & ~halt_mode;
  assign run         = ~halted & ~timer_off_ff;                              // [RQ15] [RQ16]
  assign rise        = sync_ff & ~sync_d_ff;
  assign fall        = ~sync_ff & sync_d_ff;
  assign cap1_edge   = ctrl_a_ff[`BIT_EDGE_ONE] ? rise[0] : fall[0];
  assign cap2_edge   = ctrl_b_ff[`BIT_EDGE_TWO] ? rise[1] : fall[1];
  assign ext_edge    = ctrl_b_ff[`BIT_EXT_EDGE] ? rise[2] : fall[2];
  assign done        = psel & penable & pready_ff;
  assign wr_done     = done & pwrite;
  assign rd_done     = done & ~pwrite;

  always_comb begin
    case (clk_sel)                                                           // [RQ8] [RQ23]
      `CLK_DIV4: tick = run & ((pre_ff & `PRE_DIV4) == `PRE_DIV4);
      `CLK_DIV2: tick = run & ((pre_ff & `PRE_DIV2) == `PRE_DIV2);
      `CLK_DIV8: tick = run & (pre_ff == `PRE_DIV8);
      `CLK_EXT:  tick = run & ext_edge;
      default:   tick = 1'b0;
    endcase
  end

  assign m1     = tick & (cnt_ff == duty_act_ff) & ~inhibit_ff[0];           // [RQ10] [RQ27]
  assign m2     = tick & (cnt_ff == period_act_ff) & ~inhibit_ff[1];         // [RQ10] [RQ27]
  assign reload = pwm_on & m2;
  assign ovf_ev = tick & (cnt_ff == `CNT_MAX) & ~reload;

  // ========================================================================
  // APB slave and register file
  function automatic logic acc(input logic [7:0] ofs);
    acc = done & (paddr == ofs);
  endfunction

  always_comb begin
    nxt_pready  = psel & penable & ~pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata  = prdata_ff;
    if (psel & penable & ~pready_ff) begin
      nxt_prdata = 32'h0;
      case (paddr)                                                           // [RQ19]
        `OFS_CTRL_A:  nxt_prdata[7:0] = ctrl_a_ff;
        `OFS_CTRL_B:  nxt_prdata[7:0] = ctrl_b_ff;
        `OFS_STATUS:  nxt_prdata[7:0] = {flags_ff, timer_off_ff, 2'b00};
        `OFS_CAP1_HI: nxt_prdata[7:0] = cap1_ff[15:8];
        `OFS_CAP1_LO: nxt_prdata[7:0] = cap1_ff[7:0];
        `OFS_CMP1_HI: nxt_prdata[7:0] = cmp1_ff[15:8];
        `OFS_CMP1_LO: nxt_prdata[7:0] = cmp1_ff[7:0];
        `OFS_CMP2_HI: nxt_prdata[7:0] = cmp2_ff[15:8];
        `OFS_CMP2_LO: nxt_prdata[7:0] = cmp2_ff[7:0];
        `OFS_CNT_HI, `OFS_ALT_HI: nxt_prdata[7:0] = cnt_ff[15:8];
        `OFS_CNT_LO, `OFS_ALT_LO: nxt_prdata[7:0] = cnt_ff[7:0];
        `OFS_CAP2_HI: nxt_prdata[7:0] = cap2_ff[15:8];
        `OFS_CAP2_LO: nxt_prdata[7:0] = cap2_ff[7:0];
        `OFS_SYS:     nxt_prdata[`BIT_IRQ_MASK] = irq_mask_ff;
        default:      nxt_pslverr = 1'b1;
      endcase
    end
  end

  always_comb begin
    nxt_ctrl_a    = ctrl_a_ff;
    nxt_ctrl_b    = ctrl_b_ff;
    nxt_timer_off = timer_off_ff;
    nxt_irq_mask  = irq_mask_ff;
    nxt_cmp1      = cmp1_ff;
    nxt_cmp2      = cmp2_ff;
    nxt_inhibit   = inhibit_ff;
    if (wr_done) begin
      case (paddr)
        `OFS_CTRL_A:  nxt_ctrl_a = pwdata[7:0];                              // [RQ20]
        `OFS_CTRL_B:  nxt_ctrl_b = pwdata[7:0];                              // [RQ5]
        `OFS_STATUS:  nxt_timer_off = pwdata[`BIT_TIMER_OFF];
        `OFS_SYS:     nxt_irq_mask = pwdata[`BIT_IRQ_MASK];
        `OFS_CMP1_HI: begin
          nxt_cmp1[15:8] = pwdata[7:0];
          nxt_inhibit[0] = 1'b1;                                             // [RQ10]
        end
        `OFS_CMP1_LO: begin
          nxt_cmp1[7:0]  = pwdata[7:0];
          nxt_inhibit[0] = 1'b0;                                             // [RQ10]
        end
        `OFS_CMP2_HI: begin
          nxt_cmp2[15:8] = pwdata[7:0];
          nxt_inhibit[1] = 1'b1;                                             // [RQ10]
        end
        `OFS_CMP2_LO: begin
          nxt_cmp2[7:0]  = pwdata[7:0];
          nxt_inhibit[1] = 1'b0;                                             // [RQ10]
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
      prdata_ff    <= 32'h0;
      ctrl_a_ff    <= `CTRL_RESET;
      ctrl_b_ff    <= `CTRL_RESET;
      timer_off_ff <= 1'b0;
      irq_mask_ff  <= `MASK_RESET;
      cmp1_ff      <= `CMP_RESET;
      cmp2_ff      <= `CMP_RESET;
      inhibit_ff   <= 2'b00;
    end else begin
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
      prdata_ff    <= nxt_prdata;
      ctrl_a_ff    <= nxt_ctrl_a;
      ctrl_b_ff    <= nxt_ctrl_b;
      timer_off_ff <= nxt_timer_off;
      irq_mask_ff  <= nxt_irq_mask;
      cmp1_ff      <= nxt_cmp1;
      cmp2_ff      <= nxt_cmp2;
      inhibit_ff   <= nxt_inhibit;
    end
  end

  // ========================================================================
  // Prescaler, counter, compare and output pins
  always_comb begin
    nxt_pre        = run ? pre_ff + 3'h1 : pre_ff;
    nxt_cnt        = cnt_ff;
    nxt_duty_act   = duty_act_ff;
    nxt_period_act = period_act_ff;
    nxt_lat1       = lat1_ff;
    nxt_lat2       = lat2_ff;
    if (tick) begin
      nxt_cnt = reload ? `CNT_RELOAD : cnt_ff + 16'h1;                       // [RQ9] [RQ27]
    end
    if (!pwm_on || reload) begin
      nxt_duty_act   = cmp1_ff;                                              // [RQ3]
      nxt_period_act = cmp2_ff;                                              // [RQ3]
    end
    if (pwm_on) begin
      if (m2) begin
        nxt_lat1 = ctrl_a_ff[`BIT_LVL_TWO];                                  // [RQ4] [RQ25] [RQ1]
      end else if (m1) begin
        nxt_lat1 = ctrl_a_ff[`BIT_LVL_ONE];                                  // [RQ4] [RQ6] [RQ7]
      end
    end else begin
      if (m1 || ctrl_a_ff[`BIT_FORCE_ONE]) begin
        nxt_lat1 = ctrl_a_ff[`BIT_LVL_ONE];
      end
      if (m2 || ctrl_a_ff[`BIT_FORCE_TWO]) begin
        nxt_lat2 = ctrl_a_ff[`BIT_LVL_TWO];
      end
    end
    nxt_pwm_out = nxt_lat1 & ctrl_b_ff[`BIT_PIN_EN_ONE] & ~timer_off_ff;
    nxt_out_two = nxt_lat2 & ctrl_b_ff[`BIT_PIN_EN_TWO] & ~timer_off_ff & ~pwm_on; // [RQ2]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff        <= 3'h0;
      cnt_ff        <= `CNT_RELOAD;
      duty_act_ff   <= `CMP_RESET;
      period_act_ff <= `CMP_RESET;
      lat1_ff       <= 1'b0;
      lat2_ff       <= 1'b0;
      pwm_out_ff    <= 1'b0;
      out_two_ff    <= 1'b0;
    end else begin
      pre_ff        <= nxt_pre;
      cnt_ff        <= nxt_cnt;
      duty_act_ff   <= nxt_duty_act;
      period_act_ff <= nxt_period_act;
      lat1_ff       <= nxt_lat1;
      lat2_ff       <= nxt_lat2;
      pwm_out_ff    <= nxt_pwm_out;
      out_two_ff    <= nxt_out_two;
    end
  end

  // ========================================================================
  // Power state, captures, flags and interrupt
  logic [4:0] set_ev, clr_acc;
  logic       cap1_take, cap2_take;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      timer_pwm_pkg::ST_RUN:  nxt_state = halt_mode ? timer_pwm_pkg::ST_HALT : timer_pwm_pkg::ST_RUN;
      timer_pwm_pkg::ST_HALT: nxt_state = halt_mode ? timer_pwm_pkg::ST_HALT : timer_pwm_pkg::ST_RUN;
      default:                nxt_state = timer_pwm_pkg::ST_RUN;
    endcase
  end

  always_comb begin
    nxt_arm   = arm_ff;
    cap1_take = ~pwm_on & ((~halted & cap1_edge) | (exit_halt & arm_ff[0]));  // [RQ13] [RQ17]
    cap2_take = (~halted & cap2_edge) | (exit_halt & arm_ff[1]);             // [RQ13] [RQ17]
    if (halted) begin
      nxt_arm = arm_ff | {cap2_edge, cap1_edge & ~pwm_on};                   // [RQ17]
    end
    if (exit_halt) begin
      nxt_arm = 2'b00;
    end
    nxt_cap1 = cap1_take ? cnt_ff : cap1_ff;
    nxt_cap2 = cap2_take ? cnt_ff : cap2_ff;
    set_ev[`FLG_CAPF1] = cap1_take | reload;                                 // [RQ12]
    set_ev[`FLG_CMPF1] = m1 & ~pwm_on & ~one_shot_on;                        // [RQ11]
    set_ev[`FLG_OVF]   = ovf_ev;
    set_ev[`FLG_CAPF2] = cap2_take;
    set_ev[`FLG_CMPF2] = m2 & ~pwm_on;                                       // [RQ11]
    clr_acc[`FLG_CAPF1] = acc(`OFS_CAP1_LO);                                 // [RQ26]
    clr_acc[`FLG_CMPF1] = acc(`OFS_CMP1_LO);
    clr_acc[`FLG_OVF]   = acc(`OFS_CNT_LO);
    clr_acc[`FLG_CAPF2] = acc(`OFS_CAP2_LO);
    clr_acc[`FLG_CMPF2] = acc(`OFS_CMP2_LO);
    nxt_clr_arm = clr_arm_ff & ~clr_acc;
    if (rd_done && paddr == `OFS_STATUS) begin
      nxt_clr_arm = flags_ff;                                                // [RQ26]
    end
    nxt_flags = set_ev | (flags_ff & ~(clr_arm_ff & clr_acc));               // [RQ26]
    nxt_irq   = ~irq_mask_ff & (                                             // [RQ18] [RQ15]
                (ctrl_a_ff[`BIT_CAP_IE] & (flags_ff[`FLG_CAPF1] | flags_ff[`FLG_CAPF2])) | // [RQ21] [RQ12]
                (ctrl_a_ff[`BIT_CMP_IE] & (flags_ff[`FLG_CMPF1] | flags_ff[`FLG_CMPF2])) | // [RQ22]
                (ctrl_a_ff[`BIT_OVF_IE] & flags_ff[`FLG_OVF]));              // [RQ24]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= timer_pwm_pkg::ST_RUN;
      arm_ff     <= 2'b00;
      cap1_ff    <= 16'h0;
      cap2_ff    <= 16'h0;
      flags_ff   <= 5'h00;
      clr_arm_ff <= 5'h00;
      irq_ff     <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      arm_ff     <= nxt_arm;
      cap1_ff    <= nxt_cap1;
      cap2_ff    <= nxt_cap2;
      flags_ff   <= nxt_flags;
      clr_arm_ff <= nxt_clr_arm;
      irq_ff     <= nxt_irq;
    end
  end

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign pwm_out_pin     = pwm_out_ff;
  assign compare_out_two = out_two_ff;
  assign timer_irq       = irq_ff;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_period_reload: assert property (reload |=> cnt_ff == `CNT_RELOAD)       // [RQ9]
    else $error("counter not reloaded at period match");
  a_count_step: assert property (tick && !reload |=> cnt_ff == $past(cnt_ff) + 16'h1) // [RQ27]
    else $error("counter did not advance by one");
  a_no_cmp_flag: assert property (pwm_on && flags_ff[`FLG_CMPF1:`FLG_CMPF1] == 1'b0
                                  |=> flags_ff[`FLG_CMPF1] == 1'b0)          // [RQ11]
    else $error("compare flag set in pwm mode");
  a_period_flag: assert property (reload |=> flags_ff[`FLG_CAPF1])          // [RQ12]
    else $error("capture flag one not set at period match");
  a_duty_level: assert property (pwm_on && m1 && !m2
                                 |=> lat1_ff == $past(ctrl_a_ff[`BIT_LVL_ONE])) // [RQ4]
    else $error("duty match level wrong");
  a_period_level: assert property (reload |=> lat1_ff == $past(ctrl_a_ff[`BIT_LVL_TWO])) // [RQ25]
    else $error("period match level wrong");
  a_shadow_hold: assert property (pwm_on && !reload |=> duty_act_ff == $past(duty_act_ff)) // [RQ3]
    else $error("duty shadow changed mid period");
  a_halt_freeze: assert property (halted |=> cnt_ff == $past(cnt_ff))       // [RQ16]
    else $error("counter moved in halt");
  a_inhibit_match: assert property (wr_done && paddr == `OFS_CMP1_HI |=> !m1 until inhibit_ff[0] == 1'b0) // [RQ10]
    else $error("compare ran while suspended");
  a_irq_mask: assert property (irq_mask_ff |=> !timer_irq)                  // [RQ18]
    else $error("interrupt raised while masked");
  a_cap_irq: assert property (!irq_mask_ff && ctrl_a_ff[`BIT_CAP_IE] && flags_ff[`FLG_CAPF1]
                              |=> timer_irq)                                 // [RQ21]
    else $error("capture interrupt missing");
  a_equal_level: assert property (pwm_on && ctrl_a_ff[`BIT_LVL_ONE] == ctrl_a_ff[`BIT_LVL_TWO]
                                  && lat1_ff == ctrl_a_ff[`BIT_LVL_ONE] |=> lat1_ff == $past(lat1_ff)) // [RQ7]
    else $error("pin toggled with equal levels");
  a_pwm_cap1_off: assert property (pwm_on && !reload |=> cap1_ff == $past(cap1_ff)) // [RQ13]
    else $error("capture one loaded in pwm mode");

  c_pwm_period: cover property (reload ##[1:300] reload);
  c_halt_capture: cover property (halted && cap2_edge ##[1:50] exit_halt);
  c_flag_clear: cover property (rd_done && paddr == `OFS_STATUS ##[1:20] clr_acc[`FLG_CAPF1]);
  c_irq: cover property (timer_irq);

endmodule // timer_pwm_interrupt_control

// ### shared/timer_pwm_params.svh
// Purpose: Offsets, field positions, reset values and counts of the PWM timer
// Assumes: APB with byte addresses on paddr[7:0]
// Notes:   Definitions only
`ifndef TIMER_PWM_PARAMS_SVH
`define TIMER_PWM_PARAMS_SVH

// ==========================================================================
// Register offsets
`define OFS_CTRL_A     8'h00
`define OFS_CTRL_B     8'h04
`define OFS_STATUS     8'h08
`define OFS_CAP1_HI    8'h0C
`define OFS_CAP1_LO    8'h10
`define OFS_CMP1_HI    8'h14
`define OFS_CMP1_LO    8'h18
`define OFS_CMP2_HI    8'h1C
`define OFS_CMP2_LO    8'h20
`define OFS_CNT_HI     8'h24
`define OFS_CNT_LO     8'h28
`define OFS_ALT_HI     8'h2C
`define OFS_ALT_LO     8'h30
`define OFS_CAP2_HI    8'h34
`define OFS_CAP2_LO    8'h38
`define OFS_SYS        8'h3C

// ==========================================================================
// Field positions of timer_control_a
`define BIT_CAP_IE     7
`define BIT_CMP_IE     6
`define BIT_OVF_IE     5
`define BIT_FORCE_TWO  4
`define BIT_FORCE_ONE  3
`define BIT_LVL_TWO    2
`define BIT_EDGE_ONE   1
`define BIT_LVL_ONE    0
// Field positions of timer_control_b
`define BIT_PIN_EN_ONE 7
`define BIT_PIN_EN_TWO 6
`define BIT_ONE_SHOT   5
`define BIT_PWM        4
`define BIT_CLK_HI     3
`define BIT_CLK_LO     2
`define BIT_EDGE_TWO   1
`define BIT_EXT_EDGE   0
// Flag vector index, status bit = index + 3
`define FLG_CAPF1      4
`define FLG_CMPF1      3
`define FLG_OVF        2
`define FLG_CAPF2      1
`define FLG_CMPF2      0
`define BIT_TIMER_OFF  2
`define BIT_IRQ_MASK   0

// ==========================================================================
// Encodings and values
`define CLK_DIV4       2'b00
`define CLK_DIV2       2'b01
`define CLK_DIV8       2'b10
`define CLK_EXT        2'b11
`define PRE_DIV2       3'h1
`define PRE_DIV4       3'h3
`define PRE_DIV8       3'h7
`define CNT_RELOAD     16'hFFFC
`define CNT_MAX        16'hFFFF
`define CMP_RESET      16'h8000
`define CTRL_RESET     8'h00
`define MASK_RESET     1'b1

`endif

// ### shared/timer_pwm_pkg.sv
// Purpose: Types of the PWM timer
// Assumes: Nothing
// Notes:   One-hot power state
package timer_pwm_pkg;
  // ========================================================================
  // Power state
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HALT = 2'b10
  } power_state_e;
endpackage

// ### sim/pwm_load_model.sv
// Purpose: Load on the PWM pin, logs high widths and periods in cycles
// Assumes: Pin sampled on pclk rising edge
// Notes:   Queues read by the bench
`timescale 1ns/1ps

module pwm_load_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwm_out_pin
);
  // ==========================================================================
  // Pulse logger
  int   hi_q[$];
  int   per_q[$];
  int   hi_n;
  int   per_n;
  logic last;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_n = 0;
      per_n = 0;
      last = 1'b0;
    end else begin
      if (last && !pwm_out_pin) hi_q.push_back(hi_n);
      if (pwm_out_pin && !last) begin
        if (per_n > 0) per_q.push_back(per_n);
        per_n = 0;
        hi_n = 0;
      end
      hi_n += int'(pwm_out_pin);
      per_n++;
      last = pwm_out_pin;
    end
  end
endmodule // pwm_load_model

// ### sim/timer_pwm_interrupt_control_tb_top.sv
// Purpose: Self-checking bench of the PWM timer
// Assumes: APB master, pclk 40 ns
// Notes:   Widths and periods expected from compare values
`include "timer_pwm_params.svh"
`timescale 1ns/1ps

module timer_pwm_interrupt_control_tb_top;
  localparam int PER = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        pwm_out_pin, timer_irq, halt_mode, cap_one, cap_two, ext_clk, out_two;
  logic [7:0]  paddr, rd;
  logic [31:0] pwdata, prdata;
  logic        err;
  int          failures, samples_checked, seed, duty, k;

  always #20 pclk = ~pclk;

  timer_pwm_interrupt_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_one(cap_one), .capture_input_two(cap_two), .ext_clk_pin(ext_clk), .halt_mode(halt_mode),
    .pwm_out_pin(pwm_out_pin), .compare_out_two(out_two), .timer_irq(timer_irq));
  pwm_load_model load (.pclk(pclk), .presetn(presetn), .pwm_out_pin(pwm_out_pin));

  // ==========================================================================
  // Tasks
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d}; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 16) failures++;
  endtask

  task wait_pulses(input int n);
    k = 0;
    while (load.hi_q.size() < n && k < 5000) begin @(posedge pclk); k++; end
    if (k >= 5000) failures++;
  endtask

  task end_sim;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    halt_mode = 0; cap_one = 0; cap_two = 0; ext_clk = 0; failures = 0; samples_checked = 0; seed = 48;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `OFS_CTRL_A, 8'h00); chk("ctrl_a reset", 16'h0000, {8'h00, rd});
    apb(0, 8'hFC, 8'h00); chk("unmapped err", 16'h0001, {15'h0, err});
    k = $random(seed);
    apb(1, `OFS_CTRL_A, k[7:0]); apb(0, `OFS_CTRL_A, 8'h00);
    chk("ctrl_a rw", {8'h00, k[7:0]}, {8'h00, rd});
    duty = 5 + (($random(seed) & 32'h7FFF) % 10);
    // Software start sequence
    apb(1, `OFS_CMP2_HI, 8'h00); apb(1, `OFS_CMP2_LO, 8'(PER));
    apb(1, `OFS_CMP1_HI, 8'h00); apb(1, `OFS_CMP1_LO, 8'(duty));
    apb(1, `OFS_CTRL_A, 8'h01);
    apb(1, `OFS_CTRL_B, 8'hB4);
    wait_pulses(2); load.hi_q.delete(); load.per_q.delete(); wait_pulses(2);
    chk("high width", 16'(2 * (PER - duty)), 16'(load.hi_q[$]));
    chk("period", 16'(2 * (PER + 5)), 16'(load.per_q[$]));
    // New duty lands only at a period end
    apb(1, `OFS_CMP1_HI, 8'h00); apb(1, `OFS_CMP1_LO, 8'(duty + 3));
    load.hi_q.delete(); wait_pulses(3);
    foreach (load.hi_q[i])
      if (load.hi_q[i] != 2 * (PER - duty))
        chk("width in update", 16'(2 * (PER - duty - 3)), 16'(load.hi_q[i]));
    chk("new width", 16'(2 * (PER - duty - 3)), 16'(load.hi_q[$]));
    apb(0, `OFS_STATUS, 8'h00);
    chk("cap flag one", 16'h0001, {15'h0, rd[7]});
    chk("cmp flags", 16'h0000, {14'h0, rd[6], rd[3]});
    chk("irq disabled", 16'h0000, {15'h0, timer_irq});
    apb(1, `OFS_CTRL_A, 8'h81);
    chk("irq masked", 16'h0000, {15'h0, timer_irq});
    apb(1, `OFS_SYS, 8'h00); repeat (3) @(posedge pclk);
    chk("irq raised", 16'h0001, {15'h0, timer_irq});
    // Divide by eight, second pin enabled but owned by PWM
    apb(1, `OFS_CTRL_B, 8'hF8);
    load.hi_q.delete();
    wait_pulses(3);
    chk("div8 width", 16'(8 * (PER - duty - 3)), 16'(load.hi_q[$]));
    chk("div8 period", 16'(8 * (PER + 5)), 16'(load.per_q[$]));
    chk("out two off", 16'h0000, {15'h0, out_two});
    // Equal levels hold the pin
    apb(1, `OFS_CTRL_A, 8'h05);
    cap_one <= 1'b1;
    repeat (120) @(posedge pclk);
    cap_one <= 1'b0;
    repeat (120) @(posedge pclk);
    for (int i = 0; i < 100; i++) begin
      @(negedge pclk);
      chk("steady pin", 16'h0001, {15'h0, pwm_out_pin});
    end
    // Halt freezes the counter
    @(posedge pclk);
    halt_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, `OFS_CNT_LO, 8'h00); k = int'(rd);
    repeat (20) @(posedge pclk);
    apb(0, `OFS_CNT_LO, 8'h00); chk("held count", 16'(k), {8'h00, rd});
    // Flag clear and capture arming while halted
    apb(0, `OFS_STATUS, 8'h00);
    apb(0, `OFS_CAP1_LO, 8'h00);
    chk("cap one off", 16'h0000, {8'h00, rd});
    apb(0, `OFS_STATUS, 8'h00);
    chk("cap flag one clear", 16'h0000, {15'h0, rd[7]});
    cap_two <= 1'b1;
    repeat (5) @(posedge pclk);
    cap_two <= 1'b0;
    repeat (5) @(posedge pclk);
    halt_mode <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(0, `OFS_STATUS, 8'h00);
    chk("cap flag two", 16'h0001, {15'h0, rd[4]});
    apb(0, `OFS_CAP2_LO, 8'h00);
    chk("halt capture", 16'(k), {8'h00, rd});
    end_sim;
  end

  initial begin
    #(40 * 20000);
    failures++;
    end_sim;
  end
endmodule // timer_pwm_interrupt_control_tb_top
